/* File: inc/srb_params.svh */
// Constants of the serial register bank: offsets, field masks, positions, timing.
// Included by bare name from the package; definitions only.
`ifndef SRB_PARAMS_SVH
`define SRB_PARAMS_SVH

// ======================================================================
// Register offsets, ascending; the bank walks them in this order.
`define SRB_NREG 32
`define SRB_A_HW1 7'h0e
`define SRB_A_HW2 7'h0f
`define SRB_A_GPIO 7'h17
`define SRB_A_PL5 7'h2e
`define SRB_A_PL4 7'h2f
`define SRB_A_PL3 7'h30
`define SRB_A_PL2 7'h31
`define SRB_A_PL1 7'h32
`define SRB_A_PL0 7'h33
`define SRB_A_FDR 7'h34
`define SRB_A_OTRIM 7'h38
`define SRB_A_OPT 7'h39
`define SRB_A_OCALH 7'h3a
`define SRB_A_OCALL 7'h3b
`define SRB_A_CDR1 7'h3c
`define SRB_A_CDR2 7'h3d
`define SRB_A_LIMH 7'h3e
`define SRB_A_LIML 7'h3f
`define SRB_A_SUP1 7'h40
`define SRB_A_SUP0 7'h41
`define SRB_A_THERM 7'h42
`define SRB_A_DEVF 7'h43
`define SRB_A_BUSF 7'h44
`define SRB_A_WK0 7'h45
`define SRB_A_WK1 7'h46
`define SRB_A_WKLVL 7'h48
`define SRB_A_GOC 7'h54
`define SRB_A_GOL 7'h55
`define SRB_A_SWST 7'h70
`define SRB_A_ECNT 7'h71
`define SRB_A_AVGH 7'h72
`define SRB_A_AVGL 7'h73

// ======================================================================
// Implemented-bit masks; the other bits are reserved.
`define SRB_M_HW1 8'hb5
`define SRB_M_HW2 8'hfd
`define SRB_M_GPIO 8'h07
`define SRB_M_BYTE 8'hff
`define SRB_M_FDR 8'h3f
`define SRB_M_OTRIM 8'h7f
`define SRB_M_OPT 8'h80
`define SRB_M_CDR1 8'h0d
`define SRB_M_CDR2 8'h03
`define SRB_M_SUP1 8'h63
`define SRB_M_SUP0 8'h9d
`define SRB_M_THERM 8'h0f
`define SRB_M_DEVF 8'hcf
`define SRB_M_BUSF 8'h1f
`define SRB_M_WK0 8'h31
`define SRB_M_WK1 8'h10
`define SRB_M_WKLVL 8'hd1
`define SRB_M_GPIOF 8'h40
`define SRB_M_SWST 8'h4f
`define SRB_M_ECNT 8'h3f
`define SRB_M_AVGL 8'hf0

// ======================================================================
// Lock fields, lock bits, reset and restart values.
`define SRB_IDX_HW1 0
`define SRB_IDX_HW2 1
`define SRB_BIT_LOCK_SOFT 0
`define SRB_BIT_LOCK_PERM 0
`define SRB_BIT_CP_ON 2
`define SRB_LSOFT_HW1 8'h04
`define SRB_LSOFT_GPIO 8'h07
`define SRB_LPERM_HW2 8'hfd
`define SRB_KEEP_LOCK 8'h01
`define SRB_RKEEP_PL 8'hff
`define SRB_Z 8'h00
`define SRB_RST_VAL 8'h00

// ======================================================================
// Host command register layout and bus offsets.
`define SRB_HA_CMD 4'h0
`define SRB_HA_WDATA 4'h4
`define SRB_HA_STAT 4'h8
`define SRB_HA_RDATA 4'hc
`define SRB_CMD_WR 7
`define SRB_CMD_LONG 8

// ======================================================================
// Serial clock timing made by the host.
`define SRB_REF_PERIOD_NS 4
`define SRB_SCLK_PERIOD_NS 64
`define SRB_SCLK_HALF_CYC (`SRB_SCLK_PERIOD_NS / (2 * `SRB_REF_PERIOD_NS))

`endif

/* File: inc/srb_pkg.sv */
// Types and the register map of the serial register bank.
// Assumes srb_params.svh on the include path.
package srb_pkg;
`include "srb_params.svh"

  typedef enum logic [1:0] {
    srb_k_rw = 2'h0,
    srb_k_ro = 2'h1,
    srb_k_flag = 2'h2
  } srb_kind_t;

  typedef struct packed {
    logic [6:0] addr;
    srb_kind_t kind;
    logic [7:0] used;
    logic [7:0] lsoft;
    logic [7:0] lperm;
    logic [7:0] keep;
    logic [7:0] rkeep;
  } srb_entry_t;

  typedef struct packed {
    logic hit;
    logic [4:0] idx;
  } srb_find_t;

  localparam int SRB_N = `SRB_NREG;

  localparam srb_entry_t SRB_MAP [SRB_N] = '{
    '{`SRB_A_HW1, srb_k_rw, `SRB_M_HW1, `SRB_LSOFT_HW1, `SRB_Z, `SRB_KEEP_LOCK, `SRB_Z},
    '{`SRB_A_HW2, srb_k_rw, `SRB_M_HW2, `SRB_Z, `SRB_LPERM_HW2, `SRB_KEEP_LOCK, `SRB_Z},
    '{`SRB_A_GPIO, srb_k_rw, `SRB_M_GPIO, `SRB_LSOFT_GPIO, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_PL5, srb_k_rw, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_RKEEP_PL},
    '{`SRB_A_PL4, srb_k_rw, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_RKEEP_PL},
    '{`SRB_A_PL3, srb_k_rw, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_RKEEP_PL},
    '{`SRB_A_PL2, srb_k_rw, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_RKEEP_PL},
    '{`SRB_A_PL1, srb_k_rw, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_RKEEP_PL},
    '{`SRB_A_PL0, srb_k_rw, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_RKEEP_PL},
    '{`SRB_A_FDR, srb_k_rw, `SRB_M_FDR, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_OTRIM, srb_k_rw, `SRB_M_OTRIM, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_OPT, srb_k_rw, `SRB_M_OPT, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_OCALH, srb_k_ro, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_OCALL, srb_k_ro, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_CDR1, srb_k_rw, `SRB_M_CDR1, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_CDR2, srb_k_rw, `SRB_M_CDR2, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_LIMH, srb_k_rw, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_LIML, srb_k_rw, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_SUP1, srb_k_flag, `SRB_M_SUP1, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_SUP0, srb_k_flag, `SRB_M_SUP0, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_THERM, srb_k_flag, `SRB_M_THERM, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_DEVF, srb_k_flag, `SRB_M_DEVF, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_BUSF, srb_k_flag, `SRB_M_BUSF, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_WK0, srb_k_flag, `SRB_M_WK0, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_WK1, srb_k_flag, `SRB_M_WK1, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_WKLVL, srb_k_ro, `SRB_M_WKLVL, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_GOC, srb_k_flag, `SRB_M_GPIOF, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_GOL, srb_k_flag, `SRB_M_GPIOF, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_SWST, srb_k_ro, `SRB_M_SWST, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_ECNT, srb_k_ro, `SRB_M_ECNT, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_AVGH, srb_k_ro, `SRB_M_BYTE, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z},
    '{`SRB_A_AVGL, srb_k_ro, `SRB_M_AVGL, `SRB_Z, `SRB_Z, `SRB_Z, `SRB_Z}
  };

  // ======================================================================
  // Address lookup and the next valid address after a hit.
  function automatic srb_find_t srb_find(input logic [6:0] a);
    srb_find_t f;
    f = '0;
    for (int i = 0; i < SRB_N; i++) begin
      if (SRB_MAP[i].addr == a) begin
        f.hit = 1'b1;
        f.idx = 5'(i);
      end
    end
    return f;
  endfunction

  function automatic srb_find_t srb_next(input srb_find_t f);
    srb_find_t n;
    n.hit = f.hit && (f.idx != 5'(SRB_N - 1));
    n.idx = f.idx + 5'h01;
    return n;
  endfunction
endpackage

/* File: inc/srb_spi_if.sv */
// Four-wire serial link between the host end and the register bank end.
// Assumes the host drives the clock, select and data out; the bank drives data in.
`timescale 1ns/10ps
interface srb_spi_if;
  logic sclk;
  logic cs_b;
  logic mosi;
  logic miso;

  modport dev (input sclk, input cs_b, input mosi, output miso);
  modport host (output sclk, output cs_b, output mosi, input miso);
endinterface

/* File: hw/srb_sync.sv */
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no multi-bit coherence.
`timescale 1ns/10ps
module srb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Levels.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } srb_sync_st_t;

  srb_sync_st_t st;
  srb_sync_st_t next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= {INIT, INIT};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

/* File: hw/srb_dev_end.sv */
// Register bank end of the serial link: frame decoder and the register file.
// Assumes the link pins come from another clock domain and are synchronised here.
// Overview of operation
// - POR and soft reset load reset values
// - Restart loads restart values, keeps marked bits
// - Basic frame is exactly sixteen bits
// - First byte: seven-bit address plus access bit
// - Data bits map to frame bits 8..15
// - Long frame continues at next valid address
// - Read-only and reserved bits ignore writes
// - Read/write bits store and return written value
// - Hardware-modifiable bits also updated by logic
// - Lockable bits ignore writes while locked
// - Soft lock survives soft reset; cleared by write
// - Permanent lock holds until power-on reset
// - Soft reset restores only unlocked configurations
// - Reserved bits always read as zero
// - Host writes zero into reserved bits
// - Access bit zero means read, no write
// - Access bit one writes the data byte
// - Control bits change only by host writes
// - Host changes control bits when needed
// - One address selects one eight-bit register
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module srb_dev_end
  import srb_pkg::*;
(
  // Clock and power-on reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Serial link.
  srb_spi_if.dev spi,
  // Reset events from the device.
  input wire logic soft_reset,
  input wire logic restart,
  // Hardware values and register contents.
  input wire logic [SRB_N-1:0][7:0] hw_in,
  output logic [SRB_N-1:0][7:0] reg_out
);
  typedef struct packed {
    logic sclk_d;
    logic cs_d;
    logic [5:0] cnt;
    logic [31:0] rx;
    logic miso;
    logic [SRB_N-1:0][7:0] regs;
  } srb_dev_st_t;

  srb_dev_st_t st;
  srb_dev_st_t next_st;
  logic [2:0] pins_s;
  logic sclk_s;
  logic cs_s;
  logic mosi_s;

  // ======================================================================
  // Pin synchronisation.
  srb_sync #(
    .W(3),
    .INIT(3'h2)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d({spi.sclk, spi.cs_b, spi.mosi}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_s = pins_s[1];
  assign mosi_s = pins_s[0];

  // ======================================================================
  // Read value of an entry; unimplemented bits are masked off.
  function automatic logic [7:0] rd_of(input srb_find_t f, input logic [SRB_N-1:0][7:0] r);
    logic [7:0] v;
    v = 8'h00;
    if (f.hit) begin
      v = r[f.idx] & SRB_MAP[f.idx].used;
    end
    return v;
  endfunction

  // ======================================================================
  // Frame decode and register update.
  always_comb begin
    srb_find_t f0;
    srb_find_t f1;
    srb_find_t f2;
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    logic commit;
    logic lng;
    logic soft_lk;
    logic perm_lk;
    logic we;
    logic [7:0] tx_byte;
    logic [7:0] prot;
    logic [7:0] hold;
    logic [7:0] wm;
    logic [7:0] wd;
    logic [7:0] v;
    we = 1'b0;
    tx_byte = 8'h00;
    prot = 8'h00;
    hold = 8'h00;
    wm = 8'h00;
    wd = 8'h00;
    v = 8'h00;
    next_st = st;
    f0 = srb_find(st.rx[6:0]);
    f1 = srb_next(f0);
    f2 = srb_next(f1);
    rise = sclk_s && !st.sclk_d && !cs_s;
    fall = !sclk_s && st.sclk_d && !cs_s;
    cs_fall = !cs_s && st.cs_d;
    cs_rise = cs_s && !st.cs_d;
    next_st.sclk_d = sclk_s;
    next_st.cs_d = cs_s;
    unique case (st.cnt[5:3])
      3'h1: tx_byte = rd_of(f0, st.regs);
      3'h2: tx_byte = rd_of(f1, st.regs);
      3'h3: tx_byte = rd_of(f2, st.regs);
      default: tx_byte = 8'h00;
    endcase
    if (cs_fall) begin
      next_st.cnt = 6'h00;
      next_st.rx = 32'h0000_0000;
      next_st.miso = 1'b0;
    end else if (rise) begin
      if (st.cnt < 6'd32) begin
        next_st.rx[st.cnt[4:0]] = mosi_s;
      end
      if (st.cnt != 6'h3f) begin
        next_st.cnt = st.cnt + 6'h01;
      end
    end else if (fall) begin
      next_st.miso = tx_byte[st.cnt[2:0]];
    end
    lng = (st.cnt == 6'd32);
    commit = cs_rise && st.rx[7] && ((st.cnt == 6'd16) || lng);
    soft_lk = st.regs[`SRB_IDX_HW1][`SRB_BIT_LOCK_SOFT];
    perm_lk = st.regs[`SRB_IDX_HW2][`SRB_BIT_LOCK_PERM];
    for (int i = 0; i < SRB_N; i++) begin
      prot = (soft_lk ? SRB_MAP[i].lsoft : 8'h00) | (perm_lk ? SRB_MAP[i].lperm : 8'h00);
      hold = prot | SRB_MAP[i].keep;
      v = st.regs[i];
      if (SRB_MAP[i].kind == srb_k_ro) begin
        v = hw_in[i];
      end
      if (soft_reset) begin
        v = (v & hold) | (`SRB_RST_VAL & ~hold);
      end else if (restart) begin
        v = (v & (hold | SRB_MAP[i].rkeep)) | (`SRB_RST_VAL & ~(hold | SRB_MAP[i].rkeep));
      end
      we = 1'b0;
      wd = 8'h00;
      if (commit && f0.hit && (f0.idx == 5'(i))) begin
        we = 1'b1;
        wd = st.rx[15:8];
      end else if (commit && lng && f1.hit && (f1.idx == 5'(i))) begin
        we = 1'b1;
        wd = st.rx[23:16];
      end else if (commit && lng && f2.hit && (f2.idx == 5'(i))) begin
        we = 1'b1;
        wd = st.rx[31:24];
      end
      wm = (SRB_MAP[i].kind == srb_k_ro) ? 8'h00 : (SRB_MAP[i].used & ~prot);
      if (we) begin
        v = (v & ~wm) | (wd & wm);
      end
      if (SRB_MAP[i].kind == srb_k_flag) begin
        v = v | hw_in[i];
      end
      next_st.regs[i] = v & SRB_MAP[i].used;
    end
  end

  // The power-on reset is the only event that releases the permanent lock.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= '{sclk_d: 1'b0, cs_d: 1'b1, cnt: 6'h00, rx: 32'h0000_0000, miso: 1'b0, regs: '0};
    end else begin
      st <= next_st;
    end
  end

  assign spi.miso = st.miso;
  assign reg_out = st.regs;
endmodule

/* File: hw/srb_host_end.sv */
// Host end of the serial link: takes commands over a plain register port.
// Assumes the bus master never issues read and write strobes together.
`timescale 1ns/10ps
module srb_host_end
  import srb_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Command register port.
  input wire logic [3:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  // Serial link.
  srb_spi_if.host spi
);
  typedef enum logic [4:0] {
    srb_h_idle = 5'h01,
    srb_h_lead = 5'h02,
    srb_h_shift = 5'h04,
    srb_h_trail = 5'h08,
    srb_h_gap = 5'h10
  } srb_hstate_t;

  typedef struct packed {
    srb_hstate_t state;
    logic [23:0] wdata;
    logic [23:0] rdata;
    logic lng;
    logic done;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [4:0] cnt;
    logic [3:0] div;
    logic sclk;
    logic cs_b;
    logic mosi;
    logic [31:0] rdat;
  } srb_host_st_t;

  srb_host_st_t st;
  srb_host_st_t next_st;
  logic miso_s;

  srb_sync #(
    .W(1),
    .INIT(1'h0)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d(spi.miso),
    .q(miso_s)
  );

  // Bytes sent to an unknown address are passed untouched so the bank can ignore them.
  function automatic logic [7:0] used_of(input srb_find_t f);
    return f.hit ? SRB_MAP[f.idx].used : 8'hff;
  endfunction

  // ======================================================================
  // Command port, frame sequencing and serial clock divider.
  always_comb begin
    srb_find_t f0;
    srb_find_t f1;
    srb_find_t f2;
    logic tick;
    logic [4:0] last;
    next_st = st;
    next_st.rdat = 32'h0000_0000;
    f0 = srb_find(bus_wdata[6:0]);
    f1 = srb_next(f0);
    f2 = srb_next(f1);
    tick = (st.div == 4'(`SRB_SCLK_HALF_CYC - 1));
    last = st.lng ? 5'd31 : 5'd15;
    next_st.div = tick ? 4'h0 : st.div + 4'h1;
    if (bus_rd) begin
      unique case (bus_addr)
        `SRB_HA_WDATA: next_st.rdat = {8'h00, st.wdata};
        `SRB_HA_STAT: next_st.rdat = {30'h0, st.done, st.state != srb_h_idle};
        `SRB_HA_RDATA: next_st.rdat = {8'h00, st.rdata};
        default: next_st.rdat = 32'h0000_0000;
      endcase
    end
    if (bus_wr && (bus_addr == `SRB_HA_WDATA)) begin
      next_st.wdata = bus_wdata[23:0];
    end
    unique case (st.state)
      srb_h_idle: begin
        next_st.div = 4'h0;
        if (bus_wr && (bus_addr == `SRB_HA_CMD)) begin
          next_st.tx[7:0] = {bus_wdata[`SRB_CMD_WR], bus_wdata[6:0]};
          next_st.tx[15:8] = bus_wdata[`SRB_CMD_WR] ? (st.wdata[7:0] & used_of(f0)) : 8'h00;
          next_st.tx[23:16] = bus_wdata[`SRB_CMD_WR] ? (st.wdata[15:8] & used_of(f1)) : 8'h00;
          next_st.tx[31:24] = bus_wdata[`SRB_CMD_WR] ? (st.wdata[23:16] & used_of(f2)) : 8'h00;
          next_st.lng = bus_wdata[`SRB_CMD_LONG];
          next_st.done = 1'b0;
          next_st.cnt = 5'h00;
          next_st.rx = 32'h0000_0000;
          next_st.cs_b = 1'b0;
          next_st.mosi = bus_wdata[0];
          next_st.state = srb_h_lead;
        end
      end
      srb_h_lead: begin
        if (tick) begin
          next_st.sclk = 1'b1;
          next_st.rx[0] = miso_s;
          next_st.state = srb_h_shift;
        end
      end
      srb_h_shift: begin
        if (tick && st.sclk) begin
          next_st.sclk = 1'b0;
          if (st.cnt == last) begin
            next_st.state = srb_h_trail;
          end else begin
            next_st.cnt = st.cnt + 5'h01;
            next_st.mosi = st.tx[st.cnt + 5'h01];
          end
        end else if (tick) begin
          next_st.sclk = 1'b1;
          next_st.rx[st.cnt] = miso_s;
        end
      end
      srb_h_trail: begin
        if (tick) begin
          next_st.cs_b = 1'b1;
          next_st.mosi = 1'b0;
          next_st.rdata = st.rx[31:8];
          next_st.done = 1'b1;
          next_st.state = srb_h_gap;
        end
      end
      srb_h_gap: begin
        // The select stays high long enough for the bank's synchroniser to see it.
        if (tick) begin
          next_st.state = srb_h_idle;
        end
      end
      default: next_st.state = srb_h_idle;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= '{state: srb_h_idle, cs_b: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign spi.sclk = st.sclk;
  assign spi.cs_b = st.cs_b;
  assign spi.mosi = st.mosi;
  assign bus_rdata = st.rdat;
endmodule

/* File: tb/srb_asserts.sv */
// Checker of the serial link between the host end and the register bank end.
// Assumes the interface signals are wired in directly; one clock domain.
`timescale 1ns/10ps
module srb_asserts (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Link.
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic miso
);
  logic [5:0] cnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ======================================================================
  // Rising serial clock edges seen so far in the current frame.
  always_ff @(posedge ref_clk) begin
    if (!rst_b || cs_b) begin
      cnt <= 6'h00;
    end else if ($rose(sclk)) begin
      cnt <= cnt + 6'h01;
    end
  end

  // ======================================================================
  // Wire rules.
  chk_frame_len: assert property (
    $rose(cs_b) |-> (cnt == 6'h10 || cnt == 6'h20)) else $error("frame length not 16 or 32 bits");
  chk_idle_low: assert property (
    cs_b |-> !sclk) else $error("serial clock not low outside a frame");
  chk_half_period: assert property (
    $changed(sclk) |=> $stable(sclk)[*7]) else $error("serial clock half period short");
  chk_frame_gap: assert property (
    $rose(cs_b) |=> cs_b[*7]) else $error("select gap between frames short");
  chk_select_lead: assert property (
    $fell(cs_b) |-> !sclk[*8]) else $error("clock edge too soon after select");
  chk_mosi_hold: assert property (
    sclk && $past(sclk) |-> $stable(mosi)) else $error("host data moved while clock high");
  chk_miso_addr_zero: assert property (
    $rose(sclk) && cnt < 6'h08 |-> !miso) else $error("bank data not zero in address byte");
  chk_miso_hold: assert property (
    $rose(sclk) |-> $stable(miso)) else $error("bank data moved at sampling edge");
  chk_long_tail: assert property (
    $fell(sclk) && cnt == 6'h20 |-> ##[1:10] $rose(cs_b)) else $error("long frame not closed");

  cover property ($rose(cs_b) && cnt == 6'h10);
  cover property ($rose(cs_b) && cnt == 6'h20);
  cover property ($rose(sclk) && cnt > 6'h07 && miso);
endmodule

/* File: tb/testbench.sv */
// Self-checking bench: host end and register bank end joined over the link.
// Assumes the package, the interface and both ends are compiled first.
`timescale 1ns/10ps
`include "srb_params.svh"
module testbench;
  import srb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic soft_reset = 1'b0;
  logic restart = 1'b0;
  logic [SRB_N-1:0][7:0] hw_in = '0;
  logic [SRB_N-1:0][7:0] reg_out;
  logic [7:0] exp_r [SRB_N];
  logic [31:0] rd;
  int n_errors = 0;
  int total_checks = 0;

  always #2 ref_clk = ~ref_clk;

  srb_spi_if spi_link ();
  srb_host_end u_srb_host_end (.ref_clk(ref_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .spi(spi_link.host));
  srb_dev_end u_srb_dev_end (.ref_clk(ref_clk), .rst_b(rst_b), .spi(spi_link.dev), .soft_reset(soft_reset),
    .restart(restart), .hw_in(hw_in), .reg_out(reg_out));
  srb_asserts u_srb_asserts (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(spi_link.sclk), .cs_b(spi_link.cs_b),
    .mosi(spi_link.mosi), .miso(spi_link.miso));

  // ======================================================================
  // Reporting.
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ======================================================================
  // Command port cycles.
  task automatic bwr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic brd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  // One frame: load data, start, poll until done and idle, fetch the read bytes.
  task automatic frame(input logic [31:0] cmd, input logic [31:0] wd);
    int k;
    k = 0;
    bwr(`SRB_HA_WDATA, wd);
    bwr(`SRB_HA_CMD, cmd);
    rd = 32'h0;
    while (rd[1:0] !== 2'b10 && k < 400) begin
      brd(`SRB_HA_STAT, rd);
      k++;
    end
    if (k == 400) begin
      $display("[FAIL] frame done expected 1 seen 0");
      n_errors++;
      close_out();
    end
    brd(`SRB_HA_RDATA, rd);
  endtask

  // ======================================================================
  // Register model; locks are judged on the contents before the write.
  task automatic mwrite(input int i, input logic [7:0] d);
    logic [7:0] m;
    m = (SRB_MAP[i].kind == srb_k_rw) ? SRB_MAP[i].used : 8'h00;
    if (exp_r[`SRB_IDX_HW1][`SRB_BIT_LOCK_SOFT]) begin
      m = m & ~SRB_MAP[i].lsoft;
    end
    if (exp_r[`SRB_IDX_HW2][`SRB_BIT_LOCK_PERM]) begin
      m = m & ~SRB_MAP[i].lperm;
    end
    if (SRB_MAP[i].kind == srb_k_flag) begin
      exp_r[i] = exp_r[i] & d;
    end else begin
      exp_r[i] = (exp_r[i] & ~m) | (d & m);
    end
  endtask

  task automatic mreset(input logic rs);
    logic [7:0] keep;
    for (int i = 0; i < SRB_N; i++) begin
      keep = SRB_MAP[i].keep | (rs ? SRB_MAP[i].rkeep : 8'h00);
      keep = keep | (exp_r[`SRB_IDX_HW1][0] ? SRB_MAP[i].lsoft : 8'h00);
      keep = keep | (exp_r[`SRB_IDX_HW2][0] ? SRB_MAP[i].lperm : 8'h00);
      exp_r[i] = exp_r[i] & keep;
    end
  endtask

  task automatic check_all();
    for (int i = 0; i < SRB_N; i++) begin
      if (SRB_MAP[i].kind == srb_k_ro) begin
        exp_r[i] = hw_in[i] & SRB_MAP[i].used;
      end
      if (SRB_MAP[i].kind == srb_k_flag) begin
        exp_r[i] = exp_r[i] | (hw_in[i] & SRB_MAP[i].used);
      end
      check($sformatf("reg %0d", i), 32'(exp_r[i]), 32'(reg_out[i]));
    end
  endtask

  // Access at map index i; a long frame also reaches the next two valid entries.
  task automatic op(input int i, input logic w, input logic lng, input logic [23:0] d);
    logic [23:0] e;
    frame({23'h0, lng, w, SRB_MAP[i].addr}, {8'h0, d});
    for (int k = 0; k < 3; k++) begin
      e[8*k +: 8] = (i + k < SRB_N && (k == 0 || lng)) ? exp_r[i+k] : 8'h00;
    end
    check("read bytes", 32'(e), rd & (lng ? 32'h00ffffff : 32'h000000ff));
    // Later entries first: the bank judges every byte of a frame on the locks held before it.
    for (int k = 2; k >= 0; k--) begin
      if (w && i + k < SRB_N && (k == 0 || lng)) begin
        mwrite(i + k, d[8*k +: 8]);
      end
    end
    check_all();
  endtask

  task automatic pulse(input logic rs);
    @(posedge ref_clk);
    restart <= rs;
    soft_reset <= !rs;
    @(posedge ref_clk);
    restart <= 1'b0;
    soft_reset <= 1'b0;
    mreset(rs);
    repeat (4) @(posedge ref_clk);
    check_all();
  endtask

  task automatic por();
    rst_b <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (exp_r[i]) exp_r[i] = 8'h00;
    repeat (4) @(posedge ref_clk);
    check_all();
  endtask

  task automatic hwset();
    @(posedge ref_clk);
    for (int i = 0; i < SRB_N; i++) begin
      hw_in[i] <= 8'($urandom);
    end
    repeat (4) @(posedge ref_clk);
    check_all();
  endtask

  // ======================================================================
  // Main sequence.
  initial begin
    int j;
    logic [23:0] d;
    void'($urandom(32'h9917fe40));
    por();
    // Random reads and writes, short and long; flags only ever get zeros.
    for (int n = 0; n < 40; n++) begin
      if (n % 8 == 0) begin
        hwset();
      end
      j = $urandom_range(SRB_N - 1);
      for (int k = 0; k < 3; k++) begin
        d[8*k +: 8] = (j + k < SRB_N && SRB_MAP[j+k].kind != srb_k_flag) ? 8'($urandom) : 8'h00;
      end
      op(j, 1'($urandom), 1'($urandom), d);
    end
    op(SRB_N - 1, 1'b1, 1'b1, 24'hffffff);
    frame({24'h0, 8'h81}, 32'h000000ff);
    check("unmapped frame", 32'h0, rd & 32'h000000ff);
    check_all();
    brd(4'h2, rd);
    check("unmapped port", 32'h0, rd);
    op(9, 1'b1, 1'b0, 24'hff);
    op(9, 1'b1, 1'b0, 24'h00);
    // Soft lock, its release, and soft reset around it.
    por();
    op(`SRB_IDX_HW1, 1'b1, 1'b0, 24'h05);
    op(`SRB_IDX_HW1, 1'b1, 1'b0, 24'h01);
    op(2, 1'b1, 1'b0, 24'h07);
    pulse(1'b0);
    op(`SRB_IDX_HW1, 1'b1, 1'b0, 24'h04);
    op(2, 1'b1, 1'b0, 24'h07);
    pulse(1'b0);
    // Permanent lock survives soft reset and restart; payload survives restart.
    op(`SRB_IDX_HW2, 1'b1, 1'b0, 24'h81);
    op(`SRB_IDX_HW2, 1'b1, 1'b0, 24'h7c);
    op(3, 1'b1, 1'b1, 24'h5aa53c);
    pulse(1'b1);
    pulse(1'b0);
    por();
    close_out();
  end
endmodule
